// ---- verilog/cpld_macrocell_map.svh ----
// Offsets, field positions and counts of the macrocell array model.
// Assumes a word-indexed register port: 12-bit index, 32-bit data.
`ifndef CPLD_MACROCELL_MAP_SVH
`define CPLD_MACROCELL_MAP_SVH
`define NMC 64
`define NPT 5
`define NBI 40
`define NGB 132
`define CASC_LEN 8
`define F_OR 4:0
`define F_XOR 6:5
`define F_DAT 8:7
`define F_FFM 11:9
`define F_CLK 13:12
`define F_CE 14
`define F_AR 16:15
`define F_AP 17
`define F_OREG 18
`define F_FREG 19
`define F_OE 22:20
`define F_IOM 24:23
`define F_FOLD 27:25
`define F_CASC 28
`define MODE_W 29
`define CLK_PT 2'h3
`define REG_MODE 2'h2
`define REG_SEL 3'h6
`define REG_MISC 3'h7
`define MISC_CTRL 3'h0
`define MISC_SIG 3'h1
`define MISC_FF_LO 3'h2
`define MISC_FF_HI 3'h3
`define MISC_PIN_LO 3'h4
`define MISC_PIN_HI 3'h5
`endif

// ---- verilog/cpld_macrocell_pkg.sv ----
// Types of the macrocell array model.
// Assumes the constants header sits beside it.
`include "cpld_macrocell_map.svh"
package cpld_macrocell_pkg;
	typedef enum logic [2:0]
	{
		FF_D     = 3'b000,
		FF_T     = 3'b001,
		FF_JK    = 3'b010,
		FF_SR    = 3'b011,
		FF_LATCH = 3'b100
	} ffMode_t;
	typedef enum logic [1:0]
	{
		IO_IN   = 2'b00,
		IO_OUT  = 2'b01,
		IO_BIDI = 2'b10,
		IO_RSV  = 2'b11
	} ioMode_t;
	typedef struct packed
	{
		logic [`NMC-1:0][`NPT-1:0][43:0] ptT;
		logic [`NMC-1:0][`NPT-1:0][43:0] ptC;
		logic [`NMC-1:0][`MODE_W-1:0]    mode;
		logic [3:0][`NBI-1:0][7:0]       sel;
		logic [`NMC-1:0]                 ff;
		logic [`NMC-1:0]                 clkPrev;
		logic [`NGB-1:0]                 gbus;
		logic [`NMC-1:0]                 keep;
		logic [`NMC-1:0]                 ioOut;
		logic [`NMC-1:0]                 ioOe;
		logic                            keeperEn;
		logic                            fuse;
		logic [15:0]                     sig;
		logic [31:0]                     rdData;
	} state_t;
endpackage

// ---- verilog/cpld_macrocell_logic.sv ----
// Synchronous model of a 64-macrocell programmable logic array.
// Assumes pins and strobes synchronous to clock; config via word port.
`timescale 1ns/10ps
`include "cpld_macrocell_map.svh"
module cpld_macrocell_logic
	import cpld_macrocell_pkg::*;
(
	input  logic               clock,
	input  logic               rstn,
	input  logic [3:0]         dedIn,
	input  logic [`NMC-1:0]    ioIn,
	input  logic [`NMC-1:0]    ioFloat,
	output logic [`NMC-1:0]    ioOut,
	output logic [`NMC-1:0]    ioOe,
	input  logic [11:0]        addr,
	input  logic [31:0]        wrData,
	input  logic               wrStb,
	input  logic               rdStb,
	output logic [31:0]        rdData
);

	state_t                     s_q;
	state_t                     s_d;
	logic [3:0][`NBI-1:0]       blkIn;
	logic [`NMC-1:0][`NPT-1:0]  gp;
	logic [`NMC-1:0][`NPT-1:0]  pt;
	logic [`NMC-1:0]            fold;
	logic [`NMC-1:0]            sum;
	logic [`NMC-1:0]            pinLvl;
	logic [`NMC-1:0]            fbV;
	logic [`NMC-1:0]            arV;
	logic [`NMC-1:0]            apV;
	logic [`NMC-1:0]            holdV;
	logic [`NMC-1:0]            openV;
	logic [`NMC-1:0]            dV;
	logic [`NMC-1:0]            regOutV;
	logic [`NMC-1:0]            inV;
	logic [`NMC-1:0]            xoV;
	logic [`MODE_W-1:0]         md;
	logic [7:0]                 gi;
	logic [5:0]                 mi;
	logic [2:0]                 pi;
	logic [3:0]                 rgn;
	logic                       prevSum;
	logic                       clk;
	logic                       rise;
	logic                       ce;
	logic                       xo;
	logic                       q;
	logic                       nq;
	logic                       oe;
	logic                       cfgRd;
	logic [31:0]                cfgWord;

	function automatic logic ptAnd(
		input logic [39:0] t,
		input logic [39:0] c,
		input logic [39:0] x
	);
		return &((x | ~t) & (~x | ~c));
	endfunction

	assign ioOut = s_q.ioOut;
	assign ioOe = s_q.ioOe;
	assign rdData = s_q.rdData;

	always_comb
	begin
		s_d = s_q;
		s_d.rdData = 32'h0;
		md = '0;
		gi = 8'h0;
		mi = addr[10:5];
		pi = addr[4:2];
		rgn = 4'h0;
		prevSum = 1'b0;
		clk = 1'b0;
		rise = 1'b0;
		ce = 1'b0;
		xo = 1'b0;
		q = 1'b0;
		nq = 1'b0;
		oe = 1'b0;
		cfgRd = 1'b0;
		cfgWord = 32'h0;
		// Bus is the registered copy, so feedback loops cost a cycle
		for (int b = 0; b < 4; b++)
		begin
			for (int i = 0; i < `NBI; i++)
			begin
				gi = s_q.sel[b][i];
				blkIn[b][i] = (gi < 8'd132) ? s_q.gbus[gi] : 1'b0;
			end
		end
		for (int m = 0; m < `NMC; m++)
		begin
			if (s_q.ioOe[m])
				pinLvl[m] = s_q.ioOut[m];
			else if (s_q.keeperEn && ioFloat[m])
				pinLvl[m] = s_q.keep[m];
			else
				pinLvl[m] = ioIn[m];
			s_d.keep[m] = pinLvl[m];
		end
		// Foldback is taken from the global part of a term only;
		// a term fed by its own foldback would be a loop
		for (int m = 0; m < `NMC; m++)
		begin
			md = s_q.mode[m];
			for (int p = 0; p < `NPT; p++)
			begin
				gp[m][p] = ptAnd(s_q.ptT[m][p][39:0],
					s_q.ptC[m][p][39:0], blkIn[m / 16]);
			end
			if (md[`F_FOLD] < 3'd5)
				fold[m] = ~gp[m][md[`F_FOLD]];
			else
				fold[m] = 1'b0;
		end
		for (int m = 0; m < `NMC; m++)
		begin
			md = s_q.mode[m];
			rgn = fold[(m / 4) * 4 +: 4];
			for (int p = 0; p < `NPT; p++)
			begin
				pt[m][p] = gp[m][p] & ptAnd({36'h0, s_q.ptT[m][p][43:40]},
					{36'h0, s_q.ptC[m][p][43:40]}, {36'h0, rgn});
			end
			// Chains restart every eight cells: 8 x 5 terms at most
			sum[m] = |(pt[m] & md[`F_OR])
				| (md[`F_CASC] && (m % `CASC_LEN != 0) && prevSum);
			prevSum = sum[m];
			unique case (md[`F_XOR])
				2'h0: xo = sum[m];
				2'h1: xo = ~sum[m];
				2'h2: xo = sum[m] ^ pt[m][4];
				default: xo = sum[m];
			endcase
			xoV[m] = xo;
			unique case (md[`F_DAT])
				2'h0: dV[m] = xo;
				2'h1: dV[m] = pt[m][3];
				2'h2: dV[m] = pinLvl[m];
				default: dV[m] = xo;
			endcase
			if (md[`F_CLK] == `CLK_PT)
				clk = pt[m][0];
			else
				clk = dedIn[md[`F_CLK]];
			rise = clk & ~s_q.clkPrev[m];
			s_d.clkPrev[m] = clk;
			ce = (md[`F_CLK] != `CLK_PT && md[`F_CE]) ? pt[m][1] : 1'b1;
			unique case (md[`F_AR])
				2'h0: arV[m] = 1'b0;
				2'h1: arV[m] = dedIn[3];
				2'h2: arV[m] = pt[m][2];
				2'h3: arV[m] = dedIn[3] | pt[m][2];
			endcase
			apV[m] = md[`F_AP] & pt[m][3];
			q = s_q.ff[m];
			unique case (ffMode_t'(md[`F_FFM]))
				FF_D: nq = dV[m];
				FF_T: nq = q ^ dV[m];
				FF_JK: nq = dV[m] ? (pt[m][4] ? ~q : 1'b1)
					: (pt[m][4] ? 1'b0 : q);
				FF_SR: nq = pt[m][4] ? 1'b0 : (dV[m] ? 1'b1 : q);
				FF_LATCH: nq = clk ? dV[m] : q;
				default: nq = q;
			endcase
			holdV[m] = 1'b0;
			openV[m] = 1'b0;
			if (arV[m])
				s_d.ff[m] = 1'b0;
			else if (apV[m])
				s_d.ff[m] = 1'b1;
			else if (md[`F_FFM] == FF_LATCH)
			begin
				s_d.ff[m] = nq;
				openV[m] = clk;
			end
			else if (rise && ce)
				s_d.ff[m] = nq;
			else
				holdV[m] = 1'b1;
			regOutV[m] = md[`F_OREG];
			fbV[m] = md[`F_FREG] ? q : xo;
			s_d.ioOut[m] = md[`F_OREG] ? q : xo;
			unique case (md[`F_OE])
				3'h0: oe = dedIn[0];
				3'h1: oe = ~dedIn[0];
				3'h2: oe = dedIn[1];
				3'h3: oe = ~dedIn[1];
				3'h4: oe = pinLvl[(m / 4) * 4];
				3'h5: oe = s_q.ioOut[(m / 4) * 4];
				default: oe = 1'b0;
			endcase
			inV[m] = 1'b0;
			unique case (ioMode_t'(md[`F_IOM]))
				IO_OUT: s_d.ioOe[m] = 1'b1;
				IO_BIDI: s_d.ioOe[m] = oe;
				default:
				begin
					s_d.ioOe[m] = 1'b0;
					inV[m] = 1'b1;
				end
			endcase
		end
		// Input-mode cells still feed the bus
		s_d.gbus = {fbV, pinLvl, dedIn};
		if (wrStb)
		begin
			if (!addr[11] && pi < 3'd5)
			begin
				unique case (addr[1:0])
					2'h0: s_d.ptT[mi][pi][31:0] = wrData;
					2'h1: s_d.ptC[mi][pi][31:0] = wrData;
					2'h2:
					begin
						s_d.ptT[mi][pi][43:32] = wrData[11:0];
						s_d.ptC[mi][pi][43:32] = wrData[23:12];
					end
					default: ;
				endcase
			end
			else if (addr[11:10] == `REG_MODE)
				s_d.mode[addr[5:0]] = wrData[`MODE_W-1:0];
			else if (addr[11:9] == `REG_SEL && addr[5:0] < 6'd40)
				s_d.sel[addr[7:6]][addr[5:0]] = wrData[7:0];
			else if (addr[11:9] == `REG_MISC)
			begin
				if (addr[2:0] == `MISC_CTRL)
				begin
					s_d.keeperEn = wrData[0];
					s_d.fuse = s_q.fuse | wrData[1];
				end
				else if (addr[2:0] == `MISC_SIG && !s_q.fuse)
					s_d.sig = wrData[15:0];
			end
		end
		if (rdStb)
		begin
			if (!addr[11] && pi < 3'd5)
			begin
				cfgRd = 1'b1;
				unique case (addr[1:0])
					2'h0: cfgWord = s_q.ptT[mi][pi][31:0];
					2'h1: cfgWord = s_q.ptC[mi][pi][31:0];
					2'h2: cfgWord = {8'h0, s_q.ptC[mi][pi][43:32],
						s_q.ptT[mi][pi][43:32]};
					default: cfgWord = 32'h0;
				endcase
			end
			else if (addr[11:10] == `REG_MODE)
			begin
				cfgRd = 1'b1;
				cfgWord = {3'h0, s_q.mode[addr[5:0]]};
			end
			else if (addr[11:9] == `REG_SEL && addr[5:0] < 6'd40)
			begin
				cfgRd = 1'b1;
				cfgWord = {24'h0, s_q.sel[addr[7:6]][addr[5:0]]};
			end
			if (cfgRd)
				s_d.rdData = s_q.fuse ? 32'h0 : cfgWord;
			else if (addr[11:9] == `REG_MISC)
			begin
				unique case (addr[2:0])
					`MISC_CTRL: s_d.rdData = {30'h0, s_q.fuse, s_q.keeperEn};
					`MISC_SIG: s_d.rdData = {16'h0, s_q.sig};
					`MISC_FF_LO: s_d.rdData = s_q.ff[31:0];
					`MISC_FF_HI: s_d.rdData = s_q.ff[63:32];
					`MISC_PIN_LO: s_d.rdData = pinLvl[31:0];
					`MISC_PIN_HI: s_d.rdData = pinLvl[63:32];
					default: s_d.rdData = 32'h0;
				endcase
			end
		end
	end

	// Whole array, outputs included, starts cleared and undriven
	always_ff @(posedge clock)
	begin
		if (!rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	fuse_blocks_read_a: assert property (
		rdStb && !addr[11] && s_q.fuse |=> rdData == 32'h0)
		else $error("config readback not blocked by fuse");

	signature_read_a: assert property (
		rdStb && addr[11:9] == `REG_MISC && addr[2:0] == `MISC_SIG
		|=> rdData[15:0] == $past(s_q.sig) && rdData[31:16] == 16'h0)
		else $error("signature not returned");

	reset_over_preset_a: assert property (
		|arV |=> (s_q.ff & $past(arV)) == '0)
		else $error("reset did not clear element");

	preset_sets_a: assert property (
		|(apV & ~arV) |=> (s_q.ff & $past(apV & ~arV))
		== $past(apV & ~arV))
		else $error("preset did not set element");

	edge_hold_a: assert property (
		|holdV |=> ((s_q.ff ^ $past(s_q.ff)) & $past(holdV)) == '0)
		else $error("element changed without enabled edge");

	latch_open_a: assert property (
		|openV |=> (s_q.ff & $past(openV)) == ($past(dV) & $past(openV)))
		else $error("open latch did not follow data");

	input_no_drive_a: assert property (
		|inV |=> (ioOe & $past(inV)) == '0)
		else $error("input pin driven");

	reg_output_a: assert property (
		|regOutV |=> ((ioOut ^ $past(s_q.ff)) & $past(regOutV)) == '0)
		else $error("registered output mismatch");

	keeper_hold_a: assert property (
		s_q.keeperEn ##1 s_q.keeperEn
		|-> ((s_q.keep ^ $past(s_q.keep)) & $past(ioFloat & ~s_q.ioOe))
		== '0)
		else $error("keeper lost level");

	oe_select_a: assert property (
		s_q.mode[0][`F_IOM] == IO_BIDI && s_q.mode[0][`F_OE] == 3'h2
		|=> ioOe[0] == $past(dedIn[1]))
		else $error("enable pin not followed");

	ce_blocks_a: assert property (
		s_q.mode[0][`F_CE] && s_q.mode[0][`F_CLK] != `CLK_PT
		&& !pt[0][1] && !arV[0] && !apV[0]
		&& s_q.mode[0][`F_FFM] != FF_LATCH
		|=> s_q.ff[0] == $past(s_q.ff[0]))
		else $error("disabled edge changed element");

	clear_select_a: assert property (
		s_q.mode[0][`F_AR] == 2'h1 && dedIn[3] |=> !s_q.ff[0])
		else $error("global clear did not clear element");

	rise_only_a: assert property (
		s_q.mode[0][`F_CLK] == 2'h0 && s_q.mode[0][`F_FFM] != FF_LATCH
		&& !arV[0] && !apV[0] && !(dedIn[0] && !s_q.clkPrev[0])
		|=> s_q.ff[0] == $past(s_q.ff[0]))
		else $error("element changed without rising edge");

	toggle_flip_a: assert property (
		s_q.mode[0][`F_FFM] == FF_T && s_q.mode[0][`F_CLK] == 2'h0
		&& !s_q.mode[0][`F_CE] && dedIn[0] && !s_q.clkPrev[0]
		&& dV[0] && !arV[0] && !apV[0]
		|=> s_q.ff[0] != $past(s_q.ff[0]))
		else $error("toggle element did not flip");

	comb_output_a: assert property (
		|(~regOutV) |=> ((ioOut ^ $past(xoV)) & $past(~regOutV)) == '0)
		else $error("combinatorial output mismatch");

	fuse_sticky_a: assert property (
		s_q.fuse |=> s_q.fuse)
		else $error("fuse cleared without reset");

	fb_to_bus_a: assert property (
		rstn |=> s_q.gbus[131:68] == $past(fbV))
		else $error("feedback missing from bus");

	pin_bus_a: assert property (
		rstn |=> s_q.gbus[67:4] == $past(pinLvl))
		else $error("pin level missing from bus");

endmodule

// ---- bench/pin_partner.sv ----
// Model of the board logic that faces the I/O pins of the array.
// Assumes the bench sets which pins it drives and the level it drives.
`timescale 1ns/10ps
module pin_partner
(
	input  logic [63:0] ioOut,
	input  logic [63:0] ioOe,
	input  logic [63:0] drive,
	input  logic [63:0] level,
	output logic [63:0] ioIn,
	output logic [63:0] ioFloat
);
	// Undriven pins show the inverse level so a missing keeper shows up
	always_comb
	begin
		for (int i = 0; i < 64; i++)
		begin
			if (ioOe[i])
				ioIn[i] = ioOut[i];
			else if (drive[i])
				ioIn[i] = level[i];
			else
				ioIn[i] = ~level[i];
		end
		ioFloat = ~drive & ~ioOe;
	end
endmodule

// ---- bench/cpld_macrocell_logic_tb.sv ----
// Self-checking bench for the macrocell array, scenario per task.
// Assumes the pin partner model and the design compiled before it.
`timescale 1ns/10ps
module cpld_macrocell_logic_tb;
	import cpld_macrocell_pkg::*;
	logic        clock;
	logic        rstn;
	logic        wrStb;
	logic        rdStb;
	logic [3:0]  dedIn;
	logic [11:0] addr;
	logic [31:0] wrData;
	logic [31:0] rdData;
	logic [63:0] ioIn;
	logic [63:0] ioFloat;
	logic [63:0] ioOut;
	logic [63:0] ioOe;
	logic [63:0] drv;
	logic [63:0] lvl;
	int          errors;
	int          nTests;

	cpld_macrocell_logic u_dut
	(
		.clock   (clock),
		.rstn    (rstn),
		.dedIn   (dedIn),
		.ioIn    (ioIn),
		.ioFloat (ioFloat),
		.ioOut   (ioOut),
		.ioOe    (ioOe),
		.addr    (addr),
		.wrData  (wrData),
		.wrStb   (wrStb),
		.rdStb   (rdStb),
		.rdData  (rdData)
	);

	pin_partner u_pins
	(
		.ioOut   (ioOut),
		.ioOe    (ioOe),
		.drive   (drv),
		.level   (lvl),
		.ioIn    (ioIn),
		.ioFloat (ioFloat)
	);

	always #50 clock = ~clock;

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", nTests, errors);
		if (errors == 0 && nTests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		nTests++;
		if (g !== e)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
			errors++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		addr   <= a;
		wrData <= d;
		wrStb  <= 1'b1;
		@(posedge clock);
		wrStb  <= 1'b0;
		@(posedge clock);
	endtask

	// Read data stand one cycle only, so they are judged right there
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFF_FFFF);
		addr  <= a;
		rdStb <= 1'b1;
		@(posedge clock);
		rdStb <= 1'b0;
		@(negedge clock);
		chk(rdData & m, e);
		@(posedge clock);
	endtask

	// Slow enough for the pin to term to state pipeline to settle
	task automatic gclk(input logic v);
		dedIn[0] <= v;
		tick(4);
	endtask

	task automatic s_reset;
		rd(12'hE00, 32'h0000_0000);
		rd(12'h800, 32'h0000_0000);
		chk(ioOe[31:0], 32'h0000_0000);
	endtask

	task automatic s_edge;
		wr(12'hC00, 32'h0000_0005);
		wr(12'h000, 32'h0000_0001);
		wr(12'h800, 32'h012C_0001);
		drv[2:1] <= 2'b11;
		lvl[1]   <= 1'b1;
		gclk(1'b0);
		rd(12'hE02, 32'h0000_0000);
		gclk(1'b1);
		rd(12'hE02, 32'h0000_0001);
		lvl[1] <= 1'b0;
		tick(4);
		rd(12'hE02, 32'h0000_0001);
		gclk(1'b0);
		rd(12'hE02, 32'h0000_0001);
		dedIn[1] <= 1'b1;
		tick(3);
		chk({31'h0, ioOe[0]}, 32'h0000_0001);
		chk({31'h0, ioOut[0]}, 32'h0000_0001);
		dedIn[1:0] <= 2'b01;
		tick(4);
		rd(12'hE02, 32'h0000_0000);
		chk({31'h0, ioOe[0]}, 32'h0000_0000);
	endtask

	task automatic s_enable;
		wr(12'hC01, 32'h0000_0006);
		wr(12'h004, 32'h0000_0002);
		wr(12'h800, 32'h012C_4001);
		lvl[2:1] <= 2'b01;
		gclk(1'b0);
		gclk(1'b1);
		rd(12'hE02, 32'h0000_0000);
		lvl[2] <= 1'b1;
		gclk(1'b0);
		gclk(1'b1);
		rd(12'hE02, 32'h0000_0001);
	endtask

	// Term 3 is left all zero, which reads as always true
	task automatic s_clear;
		wr(12'h800, 32'h012C_8001);
		dedIn[3] <= 1'b1;
		tick(4);
		rd(12'hE02, 32'h0000_0000);
		wr(12'h800, 32'h012E_8001);
		tick(4);
		rd(12'hE02, 32'h0000_0000);
		dedIn[3] <= 1'b0;
		tick(4);
		rd(12'hE02, 32'h0000_0001);
	endtask

	task automatic s_latch;
		wr(12'h800, 32'h012C_0801);
		lvl[1] <= 1'b0;
		tick(4);
		rd(12'hE02, 32'h0000_0000);
		lvl[1] <= 1'b1;
		tick(4);
		rd(12'hE02, 32'h0000_0001);
		gclk(1'b0);
		lvl[1] <= 1'b0;
		tick(4);
		rd(12'hE02, 32'h0000_0001);
	endtask

	task automatic s_invert;
		wr(12'h800, 32'h012C_0021);
		// Pin must reach the terms before the edge samples them
		lvl[1] <= 1'b1;
		tick(2);
		gclk(1'b1);
		rd(12'hE02, 32'h0000_0000);
	endtask

	task automatic s_toggle;
		wr(12'h800, 32'h012C_0201);
		gclk(1'b0);
		gclk(1'b1);
		rd(12'hE02, 32'h0000_0001);
		gclk(1'b0);
		gclk(1'b1);
		rd(12'hE02, 32'h0000_0000);
	endtask

	task automatic s_keep;
		wr(12'hE00, 32'h0000_0001);
		rd(12'hE00, 32'h0000_0001);
		drv[1] <= 1'b0;
		tick(4);
		rd(12'hE04, 32'h0000_0002, 32'h0000_0002);
	endtask

	task automatic s_fuse;
		wr(12'hE01, 32'h0000_A5C3);
		rd(12'h800, 32'h012C_0201);
		wr(12'hE00, 32'h0000_0003);
		rd(12'h800, 32'h0000_0000);
		rd(12'h000, 32'h0000_0000);
		wr(12'hE01, 32'h0000_1234);
		rd(12'hE01, 32'h0000_A5C3);
	endtask

	initial
	begin
		repeat (20000) @(posedge clock);
		errors++;
		report_and_stop;
	end

	initial
	begin
		clock  = 1'b0;
		rstn   = 1'b0;
		wrStb  = 1'b0;
		rdStb  = 1'b0;
		dedIn  = 4'h0;
		addr   = 12'h000;
		wrData = 32'h0000_0000;
		drv    = 64'h0;
		lvl    = 64'h0;
		errors = 0;
		nTests = 0;
		tick(12);
		rstn <= 1'b1;
		s_reset;
		s_edge;
		s_enable;
		s_clear;
		s_latch;
		s_invert;
		s_toggle;
		s_keep;
		s_fuse;
		report_and_stop;
	end
endmodule
